// [logic/serial_port_dev.sv]
// Purpose: byte-wide synchronous serial port, the device end
// Assumes: processor register port is synchronous to CLOCK
// Notes: shift edge fixed at build time by SHIFT_RISING
`timescale 1ns/1ps
module serial_port_dev #(
  parameter bit SHIFT_RISING = 1'b1
) (
  // clock and reset
  input  wire logic       CLOCK,
  input  wire logic       ARST_N,
  // processor register port
  input  wire logic [7:0] REG_ADDR,
  input  wire logic       REG_WR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       REG_RD,
  output logic      [7:0] REG_RDATA,
  // oscillator, power state and request
  input  wire logic       RTC_OSC,
  input  wire logic       HALT,
  output logic            XFER_IRQ,
  // serial lines
  serial_port_if.dev      LINK
);
  typedef enum logic [1:0] {ST_OFF, ST_IDLE, ST_SHIFT} state_e;

  state_e     state_q, state_d;
  logic [7:0] ctrl_q, ctrl_d, data_q, data_d, shift_q, shift_d, rdata_q, rdata_d;
  logic [3:0] bit_q, bit_d, rate_q, rate_d;
  logic [4:0] edge_q, edge_d;
  logic [1:0] div_q, div_d;
  logic       sck_q, sck_d, sdo_q, sdo_d, wait_q, wait_d, rtc_q;
  logic [2:0] sck_sync_q;
  logic [1:0] scs_sync_q, sdi_sync_q;
  logic       port_en, sel_en, msb_first, base_sel, is_master, busy;
  logic       base_tick, half_tick, edge_hit, rise, bit_in, done;
  serial_port_pkg::role_e role;

  function automatic logic [4:0] rate_div(logic [1:0] r);
    case (r)
      serial_port_pkg::ROLE_MASTER_QUARTER:   return serial_port_pkg::RATE_DIV_QUART;
      serial_port_pkg::ROLE_MASTER_SIXTEENTH: return serial_port_pkg::RATE_DIV_SIXT;
      default:                                return serial_port_pkg::RATE_DIV_FULL;
    endcase
  endfunction

  assign role      = serial_port_pkg::role_e'(
    ctrl_q[serial_port_pkg::ROLE_HI_BIT:serial_port_pkg::ROLE_LO_BIT]);
  assign port_en   = ctrl_q[serial_port_pkg::PORT_EN_BIT];
  assign sel_en    = ctrl_q[serial_port_pkg::SEL_EN_BIT];
  assign msb_first = ctrl_q[serial_port_pkg::MSB_FIRST_BIT];
  assign base_sel  = ctrl_q[serial_port_pkg::BASE_SEL_BIT];
  assign is_master = role != serial_port_pkg::ROLE_SLAVE;
  assign busy      = state_q == ST_SHIFT || bit_q != '0;

  // master bit timing; halt stops the system divider but not the oscillator
  always_comb begin
    div_d     = HALT ? div_q : (div_q == serial_port_pkg::BASE_HALF_LAST ? '0 : div_q + 2'h1);
    base_tick = base_sel ? RTC_OSC != rtc_q
                         : !HALT && div_q == serial_port_pkg::BASE_HALF_LAST;
    rate_d    = rate_q;
    half_tick = 1'b0;
    if (state_q != ST_SHIFT) begin
      rate_d = '0;
    end else if (base_tick) begin
      if ({1'b0, rate_q} == rate_div(role) - 5'h01) begin
        rate_d    = '0;
        half_tick = 1'b1;
      end else begin
        rate_d = rate_q + 4'h1;
      end
    end
  end

  always_comb begin
    state_d = state_q;
    ctrl_d  = ctrl_q;
    data_d  = data_q;
    shift_d = shift_q;
    bit_d   = bit_q;
    edge_d  = edge_q;
    sck_d   = sck_q;
    sdo_d   = sdo_q;
    wait_d  = wait_q;
    done    = 1'b0;
    // slave path reads only the synchronised copies, so it runs during halt
    if (is_master) begin
      edge_hit = state_q == ST_SHIFT && half_tick;
      rise     = !sck_q;
      bit_in   = LINK.sdi;
    end else begin
      edge_hit = state_q != ST_OFF && sck_sync_q[1] != sck_sync_q[2]
               && (!sel_en || !scs_sync_q[1]);
      rise     = sck_sync_q[1];
      bit_in   = sdi_sync_q[1];
    end
    if (edge_hit) begin
      sck_d  = is_master ? !sck_q : sck_q;
      edge_d = edge_q + 5'h01;
      if (rise == SHIFT_RISING) begin
        shift_d = serial_port_pkg::shift_in(shift_q, msb_first, bit_in);
        bit_d   = bit_q + 4'h1;
        done    = !is_master && bit_q == serial_port_pkg::BYTE_BITS - 4'h1;
      end else if (bit_q != '0 && bit_q != serial_port_pkg::BYTE_BITS) begin
        sdo_d = serial_port_pkg::top_bit(shift_q, msb_first);
      end
      if (is_master && edge_q == serial_port_pkg::BYTE_EDGES - 5'h01) begin
        done = 1'b1;
      end
    end
    if (!is_master && sel_en && scs_sync_q[1]) begin
      bit_d  = '0;
      edge_d = '0;
    end
    if (done) begin
      data_d  = shift_d;
      state_d = ST_IDLE;
      bit_d   = '0;
      edge_d  = '0;
    end
    if (REG_WR && REG_ADDR == serial_port_pkg::CTRL_ADDR) begin
      // flags only clear on a written zero
      ctrl_d = {REG_WDATA[7:2], ctrl_q[1:0] & REG_WDATA[1:0]};
    end
    if (REG_WR && REG_ADDR == serial_port_pkg::DATA_ADDR) begin
      if (busy) begin
        ctrl_d[serial_port_pkg::FLAG_WRITE_COLLISION_FLAG_BIT] = 1'b1;
      end else begin
        shift_d = REG_WDATA;
        if (state_q != ST_OFF) begin
          sdo_d  = serial_port_pkg::top_bit(REG_WDATA, msb_first);
          wait_d = 1'b0;
          if (is_master) begin
            state_d = ST_SHIFT;
            edge_d  = '0;
          end
        end
      end
    end
    if (done) begin
      ctrl_d[serial_port_pkg::FLAG_DONE_BIT] = 1'b1;
    end
    if (!port_en) begin
      state_d = ST_OFF;
      sdo_d   = 1'b1;
      sck_d   = 1'b0;
      bit_d   = '0;
      edge_d  = '0;
      wait_d  = 1'b0;
    end else if (state_q == ST_OFF) begin
      state_d = ST_IDLE;
      sdo_d   = 1'b0;
      sck_d   = 1'b0;
      wait_d  = 1'b1;
    end
  end

  // reads have no side effect on the shifter
  always_comb begin
    rdata_d = rdata_q;
    if (REG_RD) begin
      case (REG_ADDR)
        serial_port_pkg::CTRL_ADDR: rdata_d = ctrl_q;
        serial_port_pkg::DATA_ADDR: rdata_d = data_q;
        default:                    rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_q    <= ST_OFF;
      ctrl_q     <= serial_port_pkg::CTRL_RESET;
      data_q     <= serial_port_pkg::DATA_RESET;
      shift_q    <= serial_port_pkg::DATA_RESET;
      rdata_q    <= 8'h00;
      bit_q      <= '0;
      edge_q     <= '0;
      rate_q     <= '0;
      div_q      <= '0;
      sck_q      <= 1'b0;
      sdo_q      <= 1'b1;
      wait_q     <= 1'b0;
      rtc_q      <= 1'b0;
      sck_sync_q <= '0;
      scs_sync_q <= 2'h3;
      sdi_sync_q <= 2'h3;
    end else begin
      state_q    <= state_d;
      ctrl_q     <= ctrl_d;
      data_q     <= data_d;
      shift_q    <= shift_d;
      rdata_q    <= rdata_d;
      bit_q      <= bit_d;
      edge_q     <= edge_d;
      rate_q     <= rate_d;
      div_q      <= div_d;
      sck_q      <= sck_d;
      sdo_q      <= sdo_d;
      wait_q     <= wait_d;
      rtc_q      <= RTC_OSC;
      sck_sync_q <= {sck_sync_q[1:0], LINK.sck};
      scs_sync_q <= {scs_sync_q[0], LINK.slave_select_n};
      sdi_sync_q <= {sdi_sync_q[0], LINK.sdi};
    end
  end

  assign REG_RDATA       = rdata_q;
  assign XFER_IRQ        = ctrl_q[serial_port_pkg::FLAG_DONE_BIT];
  // line roles: clock and select out in master role only
  assign LINK.dev_sck_o  = sck_q;
  assign LINK.dev_sck_oe = state_q != ST_OFF && is_master;
  assign LINK.dev_scs_o  = !(wait_q || state_q == ST_SHIFT);
  assign LINK.dev_scs_oe = state_q != ST_OFF && is_master && sel_en;
  assign LINK.dev_sdo_o  = sdo_q;
  assign LINK.dev_sdi_o  = 1'b0;
  assign LINK.dev_sdi_oe = wait_q;
endmodule

// [logic/serial_port_if.sv]
// Purpose: the four serial lines between the port and its far party
// Assumes: each party gives output and enable per driven line, device data out without enable
// Notes: undriven clock reads low, select and data read high
`timescale 1ns/1ps
interface serial_port_if;
  logic dev_sck_o;
  logic dev_sck_oe;
  logic dev_scs_o;
  logic dev_scs_oe;
  logic dev_sdo_o;
  logic dev_sdi_o;
  logic dev_sdi_oe;
  logic peer_sck_o;
  logic peer_sck_oe;
  logic peer_scs_o;
  logic peer_scs_oe;
  logic peer_sdo_o;
  logic peer_sdo_oe;
  logic sck;
  logic slave_select_n;
  logic sdi;
  logic sdo;

  assign sck            = dev_sck_oe ? dev_sck_o : (peer_sck_oe ? peer_sck_o : 1'b0);
  assign slave_select_n = dev_scs_oe ? dev_scs_o : (peer_scs_oe ? peer_scs_o : 1'b1);
  assign sdi            = peer_sdo_oe ? peer_sdo_o : (dev_sdi_oe ? dev_sdi_o : 1'b1);
  assign sdo            = dev_sdo_o;

  modport dev (
    output dev_sck_o, dev_sck_oe, dev_scs_o, dev_scs_oe, dev_sdo_o, dev_sdi_o, dev_sdi_oe,
    input  sck, slave_select_n, sdi
  );
  modport peer (
    output peer_sck_o, peer_sck_oe, peer_scs_o, peer_scs_oe, peer_sdo_o, peer_sdo_oe,
    input  sck, slave_select_n, sdo
  );
endinterface

// [logic/serial_port_peer.sv]
// Purpose: far party of the serial port, master or slave by a level
// Assumes: link lines are synchronous to CLOCK
// Notes: bytes to send wait in a small buffer with valid and ready
`timescale 1ns/1ps
module serial_port_peer #(
  parameter bit SHIFT_RISING = 1'b1,
  parameter int DEPTH        = 2,
  parameter int HALF_PERIOD  = 8
) (
  // clock and reset
  input  wire logic       CLOCK,
  input  wire logic       ARST_N,
  // role
  input  wire logic       ROLE_MASTER,
  input  wire logic       USE_SELECT,
  input  wire logic       MSB_FIRST,
  // bytes to send
  input  wire logic [7:0] TX_DATA,
  input  wire logic       TX_VALID,
  output logic            TX_READY,
  // bytes received
  output logic      [7:0] RX_DATA,
  output logic            RX_VALID,
  // serial lines
  serial_port_if.peer     LINK
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [15:0] HALF_LAST = 16'(HALF_PERIOD - 1);

  typedef enum logic {P_IDLE, P_SHIFT} state_e;

  logic [7:0]    mem_q [DEPTH];
  logic [PW-1:0] rd_q, rd_d, wr_q, wr_d;
  logic [CW-1:0] cnt_q, cnt_d;
  state_e        state_q, state_d;
  logic [7:0]    shift_q, shift_d, rx_q, rx_d, tx_src;
  logic [15:0]   hc_q, hc_d;
  logic [3:0]    bit_q, bit_d;
  logic [4:0]    edge_q, edge_d;
  logic          sck_q, sck_d, sdo_q, sdo_d, prev_q, rxv_q, rxv_d;
  logic          sel, edge_hit, rise, push, pop, done;

  assign TX_READY = cnt_q != CW'(DEPTH);
  assign push     = TX_VALID && TX_READY;
  assign tx_src   = (cnt_q != '0) ? mem_q[rd_q] : serial_port_pkg::IDLE_FILL;
  assign sel      = ROLE_MASTER || !USE_SELECT || !LINK.slave_select_n;

  always_comb begin
    state_d  = state_q;
    shift_d  = shift_q;
    hc_d     = hc_q;
    bit_d    = bit_q;
    edge_d   = edge_q;
    sck_d    = sck_q;
    sdo_d    = sdo_q;
    rx_d     = rx_q;
    rxv_d    = 1'b0;
    done     = 1'b0;
    edge_hit = 1'b0;
    rise     = 1'b0;
    if (ROLE_MASTER) begin
      edge_hit = state_q == P_SHIFT && hc_q == HALF_LAST;
      rise     = !sck_q;
      if (state_q == P_SHIFT) begin
        hc_d = edge_hit ? '0 : hc_q + 16'h0001;
      end else if (cnt_q != '0) begin
        state_d = P_SHIFT;
        shift_d = mem_q[rd_q];
        sdo_d   = serial_port_pkg::top_bit(mem_q[rd_q], MSB_FIRST);
        hc_d    = '0;
      end
    end else begin
      edge_hit = sel && LINK.sck != prev_q;
      rise     = LINK.sck;
      if (bit_q == '0 && !edge_hit) begin
        shift_d = tx_src;
        sdo_d   = serial_port_pkg::top_bit(tx_src, MSB_FIRST);
      end
    end
    if (edge_hit) begin
      sck_d  = ROLE_MASTER ? !sck_q : sck_q;
      edge_d = edge_q + 5'h01;
      if (rise == SHIFT_RISING) begin
        shift_d = serial_port_pkg::shift_in(shift_q, MSB_FIRST, LINK.sdo);
        bit_d   = bit_q + 4'h1;
        done    = !ROLE_MASTER && bit_q == serial_port_pkg::BYTE_BITS - 4'h1;
      end else if (bit_q != '0 && bit_q != serial_port_pkg::BYTE_BITS) begin
        sdo_d = serial_port_pkg::top_bit(shift_q, MSB_FIRST);
      end
      if (ROLE_MASTER && edge_q == serial_port_pkg::BYTE_EDGES - 5'h01) begin
        done = 1'b1;
      end
    end
    if (!sel) begin
      bit_d  = '0;
      edge_d = '0;
    end
    if (done) begin
      rx_d    = shift_d;
      rxv_d   = 1'b1;
      state_d = P_IDLE;
      bit_d   = '0;
      edge_d  = '0;
    end
  end

  // a stalled far master blocks new frames in slave role, so the buffer really fills
  assign pop  = done && cnt_q != '0;
  assign rd_d = pop ? PW'((32'(rd_q) + 1) % DEPTH) : rd_q;
  assign wr_d = push ? PW'((32'(wr_q) + 1) % DEPTH) : wr_q;
  assign cnt_d = cnt_q + CW'(push) - CW'(pop);

  always_ff @(posedge CLOCK) begin
    if (push) begin
      mem_q[wr_q] <= TX_DATA;
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_q <= P_IDLE;
      shift_q <= serial_port_pkg::IDLE_FILL;
      rx_q    <= serial_port_pkg::DATA_RESET;
      rxv_q   <= 1'b0;
      hc_q    <= '0;
      bit_q   <= '0;
      edge_q  <= '0;
      sck_q   <= 1'b0;
      sdo_q   <= 1'b1;
      prev_q  <= 1'b0;
      rd_q    <= '0;
      wr_q    <= '0;
      cnt_q   <= '0;
    end else begin
      state_q <= state_d;
      shift_q <= shift_d;
      rx_q    <= rx_d;
      rxv_q   <= rxv_d;
      hc_q    <= hc_d;
      bit_q   <= bit_d;
      edge_q  <= edge_d;
      sck_q   <= sck_d;
      sdo_q   <= sdo_d;
      prev_q  <= LINK.sck;
      rd_q    <= rd_d;
      wr_q    <= wr_d;
      cnt_q   <= cnt_d;
    end
  end

  assign RX_DATA          = rx_q;
  assign RX_VALID         = rxv_q;
  assign LINK.peer_sck_o  = sck_q;
  assign LINK.peer_sck_oe = ROLE_MASTER;
  assign LINK.peer_scs_o  = state_q != P_SHIFT;
  assign LINK.peer_scs_oe = ROLE_MASTER && USE_SELECT;
  assign LINK.peer_sdo_o  = sdo_q;
  assign LINK.peer_sdo_oe = ROLE_MASTER ? state_q == P_SHIFT : sel;
endmodule

// [logic/serial_port_pkg.sv]
// Purpose: shared constants, types and bit helpers of the serial port
// Assumes: byte-wide frames, CLOCK at 50 MHz
// Notes: register offsets and bit positions of the control register
package serial_port_pkg;

  // processor register offsets
  localparam logic [7:0] CTRL_ADDR = 8'h1f;
  localparam logic [7:0] DATA_ADDR = 8'h1e;

  // control register fields
  localparam int FLAG_DONE_BIT = 0;
  localparam int FLAG_WRITE_COLLISION_FLAG_BIT = 1;
  localparam int SEL_EN_BIT    = 2;
  localparam int MSB_FIRST_BIT = 3;
  localparam int PORT_EN_BIT   = 4;
  localparam int ROLE_LO_BIT   = 5;
  localparam int ROLE_HI_BIT   = 6;
  localparam int BASE_SEL_BIT  = 7;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] IDLE_FILL  = 8'hff;

  typedef enum logic [1:0] {
    ROLE_MASTER_FULL      = 2'h0,
    ROLE_MASTER_QUARTER   = 2'h1,
    ROLE_MASTER_SIXTEENTH = 2'h2,
    ROLE_SLAVE            = 2'h3
  } role_e;

  // base rate is the system clock over four; a half bit is half of that
  localparam int          BASE_DIV       = 4;
  localparam logic [1:0]  BASE_HALF_LAST = 2'(BASE_DIV / 2 - 1);
  localparam logic [4:0]  RATE_DIV_FULL  = 5'h01;
  localparam logic [4:0]  RATE_DIV_QUART = 5'h04;
  localparam logic [4:0]  RATE_DIV_SIXT  = 5'h10;
  localparam logic [3:0]  BYTE_BITS      = 4'h8;
  localparam logic [4:0]  BYTE_EDGES     = 5'h10;

  function automatic logic [7:0] shift_in(logic [7:0] b, logic msb, logic bit_in);
    return msb ? {b[6:0], bit_in} : {bit_in, b[7:1]};
  endfunction

  function automatic logic top_bit(logic [7:0] b, logic msb);
    return msb ? b[7] : b[0];
  endfunction

endpackage

// [sim/serial_port_monitor.sv]
// Purpose: line checks between the device and its far party
// Assumes: one clock domain, CLOCK rising edge
// Notes: watches the interface lines only
`timescale 1ns/1ps
module serial_port_monitor (
  // clock and reset
  input wire logic CLOCK,
  input wire logic ARST_N,
  // device side
  input wire logic dev_sck_o,
  input wire logic dev_sck_oe,
  input wire logic dev_scs_o,
  input wire logic dev_scs_oe,
  input wire logic dev_sdo_o,
  input wire logic dev_sdi_o,
  input wire logic dev_sdi_oe,
  // far side
  input wire logic peer_sck_oe,
  input wire logic peer_scs_oe,
  // resolved lines
  input wire logic sck,
  input wire logic slave_select_n,
  input wire logic sdo
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!ARST_N);

  chk_enable_lines_low: assert property (
    $rose(dev_sck_oe) |-> !dev_sck_o && !dev_sdo_o && dev_sdi_oe && !dev_sdi_o)
    else $error("lines not low at enable");
  chk_select_enable_low: assert property (
    $rose(dev_scs_oe) |-> !dev_scs_o)
    else $error("select not low when first driven");
  chk_sck_half_min: assert property (
    dev_sck_oe && $changed(dev_sck_o) |=> $stable(dev_sck_o))
    else $error("master clock half period below two cycles");
  chk_select_in_frame: assert property (
    dev_sck_oe && dev_scs_oe && $changed(dev_sck_o) |-> !$past(dev_scs_o))
    else $error("master clock toggles while select high");
  chk_peer_select_frame: assert property (
    peer_sck_oe && peer_scs_oe && $changed(sck) |-> !$past(slave_select_n))
    else $error("far clock toggles while select high");
  chk_data_at_edge: assert property (
    $rose(sck) |-> $stable(sdo))
    else $error("data out moves on the sampling edge");
  chk_disable_release: assert property (
    $fell(dev_sck_oe) |-> dev_sdo_o && !dev_sdi_oe && !dev_scs_oe)
    else $error("lines not released at disable");
  chk_one_clock_drv: assert property (
    !(dev_sck_oe && peer_sck_oe))
    else $error("both parties drive the clock");
  chk_one_select_drv: assert property (
    !(dev_scs_oe && peer_scs_oe))
    else $error("both parties drive select");
endmodule

// [sim/sync_serial_port_tb.sv]
// Purpose: device and peer back to back through the serial lines
// Assumes: CLOCK 50 MHz, peer half period of 8 cycles
// Notes: all roles and rates, flags, collision, halt, buffer fill
`timescale 1ns/1ps
`define CHECK(what, exp, got) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
      n_mismatch++; \
      $display("wrong value %s expected %0h seen %0h", what, exp, got); \
    end \
  end
module sync_serial_port_tb;
  logic       clock;
  logic       arst_n;
  logic [7:0] reg_addr;
  logic       reg_wr;
  logic [7:0] reg_wdata;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic [2:0] rtc_div;
  logic       halt;
  logic       xfer_irq;
  logic       role_master;
  logic       use_select;
  logic       msb_first;
  logic [7:0] tx_data;
  logic       tx_valid;
  logic       tx_ready;
  logic [7:0] rx_data;
  logic       rx_valid;
  logic [7:0] rx_last;
  int         rx_count;
  int         n_mismatch;
  int         samples_checked;
  int         n;
  // ctrl, byte sent, byte expected back, half-bit multiple
  localparam logic [7:0] cfg_ctrl [6] = '{8'h1c, 8'h34, 8'h5c, 8'h9c, 8'h7c, 8'h78};
  localparam logic [7:0] cfg_tx [6]   = '{8'ha5, 8'hc3, 8'h81, 8'h01, 8'h96, 8'h3e};
  localparam logic [7:0] cfg_rx [6]   = '{8'h3c, 8'h5a, 8'h0f, 8'hf0, 8'he1, 8'h7b};
  localparam int         cfg_mul [4]  = '{1, 4, 16, 2};

  serial_port_if serial_port_if_inst ();

  serial_port_dev serial_port_dev_inst (
    .CLOCK     (clock),
    .ARST_N    (arst_n),
    .REG_ADDR  (reg_addr),
    .REG_WR    (reg_wr),
    .REG_WDATA (reg_wdata),
    .REG_RD    (reg_rd),
    .REG_RDATA (reg_rdata),
    .RTC_OSC   (rtc_div[2]),
    .HALT      (halt),
    .XFER_IRQ  (xfer_irq),
    .LINK      (serial_port_if_inst.dev)
  );

  serial_port_peer serial_port_peer_inst (
    .CLOCK       (clock),
    .ARST_N      (arst_n),
    .ROLE_MASTER (role_master),
    .USE_SELECT  (use_select),
    .MSB_FIRST   (msb_first),
    .TX_DATA     (tx_data),
    .TX_VALID    (tx_valid),
    .TX_READY    (tx_ready),
    .RX_DATA     (rx_data),
    .RX_VALID    (rx_valid),
    .LINK        (serial_port_if_inst.peer)
  );

  serial_port_monitor serial_port_monitor_inst (
    .CLOCK          (clock),
    .ARST_N         (arst_n),
    .dev_sck_o      (serial_port_if_inst.dev_sck_o),
    .dev_sck_oe     (serial_port_if_inst.dev_sck_oe),
    .dev_scs_o      (serial_port_if_inst.dev_scs_o),
    .dev_scs_oe     (serial_port_if_inst.dev_scs_oe),
    .dev_sdo_o      (serial_port_if_inst.dev_sdo_o),
    .dev_sdi_o      (serial_port_if_inst.dev_sdi_o),
    .dev_sdi_oe     (serial_port_if_inst.dev_sdi_oe),
    .peer_sck_oe    (serial_port_if_inst.peer_sck_oe),
    .peer_scs_oe    (serial_port_if_inst.peer_scs_oe),
    .sck            (serial_port_if_inst.sck),
    .slave_select_n (serial_port_if_inst.slave_select_n),
    .sdo            (serial_port_if_inst.sdo)
  );

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // oscillator level changes every four cycles, one half-bit tick each
  always @(posedge clock) begin
    rtc_div <= rtc_div + 3'h1;
    if (rx_valid === 1'b1) begin
      rx_last  <= rx_data;
      rx_count <= rx_count + 1;
    end
  end

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr    <= 1'b0;
  endtask

  task automatic expect_reg(input logic [7:0] a, input logic [7:0] e, input string what);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd   <= 1'b0;
    #1 `CHECK(what, e, reg_rdata)
  endtask

  // only called while the peer buffer has room
  task automatic push(input logic [7:0] d);
    @(posedge clock);
    tx_data  <= d;
    tx_valid <= 1'b1;
    @(posedge clock);
    tx_valid <= 1'b0;
  endtask

  task automatic wait_done();
    n = 0;
    while (xfer_irq !== 1'b1 && n < 4000) begin
      @(posedge clock);
      #1 n++;
    end
    `CHECK("done request", 1'b1, xfer_irq)
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    repeat (10000) @(posedge clock);
    n_mismatch++;
    print_verdict();
  end

  initial begin
    {arst_n, reg_wr, reg_rd, halt, tx_valid, role_master} = '0;
    {reg_addr, reg_wdata, tx_data, rx_last, rtc_div} = '0;
    {use_select, msb_first} = 2'h3;
    rx_count = 0;
    n_mismatch = 0;
    samples_checked = 0;
    repeat (5) @(posedge clock);
    arst_n <= 1'b1;
    expect_reg(serial_port_pkg::CTRL_ADDR, 8'h00, "control");
    expect_reg(serial_port_pkg::DATA_ADDR, 8'h00, "data");
    expect_reg(8'h2a, 8'h00, "unmapped");
    `CHECK("idle sdo", 1'b1, serial_port_if_inst.sdo)
    push(8'h3c);
    push(8'h5a);
    #1 `CHECK("peer buffer full", 1'b0, tx_ready)
    for (int i = 0; i < 6; i++) begin
      if (i == 4) begin
        reg_write(serial_port_pkg::CTRL_ADDR, 8'h00);
        @(posedge clock);
        #1 `CHECK("released clock", 1'b0, serial_port_if_inst.dev_sck_oe)
        `CHECK("disabled sdo", 1'b1, serial_port_if_inst.sdo)
        // hand the clock over only once the device has let go of it
        @(posedge clock);
        role_master <= 1'b1;
      end
      msb_first  <= cfg_ctrl[i][3];
      use_select <= cfg_ctrl[i][2];
      halt       <= (i >= 3);
      if (i == 2 || i == 3) push(cfg_rx[i]);
      reg_write(serial_port_pkg::CTRL_ADDR, cfg_ctrl[i]);
      reg_write(serial_port_pkg::DATA_ADDR, cfg_tx[i]);
      // a slave between frames accepts writes, so no collision there
      if (i < 4) reg_write(serial_port_pkg::DATA_ADDR, 8'h77);
      else push(cfg_rx[i]);
      wait_done();
      if (i < 4) `CHECK("frame length", 1'b1, n > 28 * cfg_mul[i] && n < 32 * cfg_mul[i] + 10)
      expect_reg(serial_port_pkg::CTRL_ADDR, cfg_ctrl[i] | (i < 4 ? 8'h03 : 8'h01), "flags");
      expect_reg(serial_port_pkg::DATA_ADDR, cfg_rx[i], "received");
      // a far master ends its frame a half bit after its last sampling edge, about five cycles after the device flags it
      n = 0;
      while (rx_count != i + 1 && n < 64) begin
        @(posedge clock);
        #1 n++;
      end
      `CHECK("peer received", cfg_tx[i], rx_last)
      `CHECK("frame count", i + 1, rx_count)
      reg_write(serial_port_pkg::CTRL_ADDR, cfg_ctrl[i]);
      @(posedge clock);
      #1 `CHECK("request cleared", 1'b0, xfer_irq)
    end
    print_verdict();
  end
endmodule
